// ==== design/ext_regs_defs.svh ====
// offsets, field positions, reset values and port addresses of the extension bank
`ifndef EXT_REGS_DEFS_SVH
`define EXT_REGS_DEFS_SVH
`define IDX_PORT_MONO 16'h03b6
`define IDX_PORT_COLOR 16'h03d6
`define DATA_PORT_MONO 16'h03b7
`define DATA_PORT_COLOR 16'h03d7
`define IDX_CHIP_VERSION 7'h00
`define IDX_STRAP_CONFIG 7'h01
`define VERSION_BASE 8'h40
`define INDEX_MASK 8'h7f
`define INDEX_RESET 7'h00
`define CFG_BUS_LO 0
`define CFG_OSC 2
`define CFG_MCLK 3
`define CFG_XCVR 4
`define CFG_PIPE 5
`define CLK_PIN_COUNT 4
`endif

// ==== design/ext_regs_pkg.sv ====
// types shared by the extension register bank
package ext_regs_pkg;
    typedef enum logic [1:0] {
        BUS_PERIPH = 2'b00,
        BUS_CHANNEL = 2'b01,
        BUS_LOCAL = 2'b10,
        BUS_ISA = 2'b11
    } host_bus_t;

    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_HELD = 2'b01
    } cap_state_t;

    typedef struct packed {
        logic [6:0] index;
        logic [7:0] strap;
        cap_state_t cap;
        logic [7:0] rdata;
        logic [1:0] clksel;
        logic [3:0] pclk_onehot;
    } ext_state_t;
endpackage

// ==== design/ext_index_strap_cfg.sv ====
// extension index/data ports, version and reset-latched strap configuration
// Overview of operation
// - index is 7 bits, bit 7 reads zero
// - index written and read back at index port
// - index 00h reads version; writes ignored
// - version is base code plus stepping number
// - strap register latches address bus at reset
// - only strap bits 0-5 drive logic
// - straps 0-5 default high via pullups
// - strap bits 1-0 select host bus type
// - bit2 zero: all clock pins are inputs
// - bit2 one: pins 2,3 become select outputs
// - bit3 picks memory clock frequency
// - oscillators: mclk from pin1 or pin0
// - clock chip codes 0-3 map frequencies
// - bit3 set: code 1 means 28.322 MHz
// - selection follows crt or panel bits
// - bit4 assigns transceiver or panel supply pin
// - fixed-reset bits forced, others kept
// - unimplemented bits read zero
`timescale 1ns/100ps
`include "ext_regs_defs.svh"
module ext_index_strap_cfg #(
    parameter logic [3:0] STEPPING = 4'h0 // arbitrary stepping value
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_hit_o,
    input wire logic color_base_i,
    input wire logic [7:0] memory_address_bus_a_i,
    input wire logic panel_mode_i,
    input wire logic [1:0] misc_output_reg_clk_i,
    input wire logic [1:0] feature_control_reg_clk_i,
    input wire logic [3:0] panel_interface_reg_clk_i,
    input wire logic transceiver_read_dir_i,
    input wire logic panel_supply_enable_n_i,
    output ext_regs_pkg::host_bus_t host_bus_o,
    output logic pixel_clock_source_sel_o,
    output logic memory_clock_freq_sel_o,
    output logic [3:0] clock_pin_oe_o,
    output logic [3:0] clock_pin_out_o,
    output logic [3:0] pixel_clock_input_o,
    output logic [1:0] mclk_pin_o,
    output logic [1:0] clock_select_o,
    output logic pin82_o
);
    import ext_regs_pkg::*;

    // registered state and its next value
    ext_state_t st_ff;
    ext_state_t nxt_st;

    // port decode
    logic idx_sel;
    logic dat_sel;
    logic rd_idx;
    logic rd_dat;
    logic wr_idx;
    logic wr_dat;

    // strap fields that reach the logic
    logic [7:0] pulled;
    logic [7:0] strap_live;
    logic [1:0] strap_bus;
    logic clk_chip;
    logic mclk_slow;
    logic no_xcvr;

    // pixel clock selection
    logic [1:0] crt_code;
    logic [1:0] panel_code;
    logic [1:0] code;
    logic [3:0] pclk_next;

    // read data candidates
    logic [7:0] index_word;
    logic [7:0] version_word;
    logic [7:0] data_word;
    logic [7:0] read_word;

    // clock pin drive
    logic [3:0] pin_drive;
    logic [3:0] pin_level;

    // port decode at the active mono or colour base
    function automatic logic port_hit(input logic [15:0] a, input logic [15:0] mono,
                                      input logic [15:0] color, input logic cb);
        if (cb) begin
            port_hit = (a == color);
        end else begin
            port_hit = (a == mono);
        end
    endfunction

    // select code: high bit set takes the explicit pair, else zero and the low bit
    function automatic logic [1:0] sel_code(input logic hi, input logic lo,
                                            input logic [1:0] pair);
        if (hi) begin
            sel_code = pair;
        end else begin
            sel_code = {1'h0, lo};
        end
    endfunction

    // oscillator pin that carries the pixel clock for a select code
    function automatic logic [3:0] osc_pin(input logic [1:0] c);
        case (c)
            2'h0: begin
                osc_pin = 4'h4;
            end
            2'h1: begin
                osc_pin = 4'h2;
            end
            2'h2: begin
                osc_pin = 4'h1;
            end
            default: begin
                osc_pin = 4'h8;
            end
        endcase
    endfunction

    // data port word for the selected extension index
    function automatic logic [7:0] ext_word(input logic [6:0] idx, input logic [7:0] strap,
                                            input logic [7:0] ver);
        case (idx)
            `IDX_CHIP_VERSION: begin
                ext_word = ver;
            end
            `IDX_STRAP_CONFIG: begin
                ext_word = strap;
            end
            default: begin
                ext_word = 8'h00;
            end
        endcase
    endfunction

    // host bus type from strap bits 1-0
    function automatic host_bus_t bus_of(input logic [1:0] s);
        case (s)
            2'h0: begin
                bus_of = BUS_PERIPH;
            end
            2'h1: begin
                bus_of = BUS_CHANNEL;
            end
            2'h2: begin
                bus_of = BUS_LOCAL;
            end
            default: begin
                bus_of = BUS_ISA;
            end
        endcase
    endfunction

    // strobes qualified by the port decode
    assign idx_sel = port_hit(io_addr_i, `IDX_PORT_MONO, `IDX_PORT_COLOR, color_base_i);
    assign dat_sel = port_hit(io_addr_i, `DATA_PORT_MONO, `DATA_PORT_COLOR, color_base_i);
    assign rd_idx = io_rd_i & idx_sel;
    assign rd_dat = io_rd_i & dat_sel;
    assign wr_idx = io_wr_i & idx_sel;
    assign wr_dat = io_wr_i & dat_sel;
    assign io_hit_o = rd_idx | rd_dat | wr_idx | wr_dat;

    // pullups on pins 0-5 sit outside this logic; pin levels pass straight in
    assign pulled = memory_address_bus_a_i;

    // bits 6-7 are readable only and never reach the logic
    for (genvar i = 0; i < 8; i++) begin : g_strap
        if (i < 6) begin : g_live
            assign strap_live[i] = st_ff.strap[i];
        end else begin : g_dead
            assign strap_live[i] = 1'h0;
        end
    end

    assign strap_bus = strap_live[`CFG_BUS_LO +: 2];
    assign clk_chip = strap_live[`CFG_OSC];
    assign mclk_slow = strap_live[`CFG_MCLK];
    assign no_xcvr = strap_live[`CFG_XCVR];

    // pixel clock select code from crt or panel bits
    assign crt_code = sel_code(misc_output_reg_clk_i[1], misc_output_reg_clk_i[0],
                               feature_control_reg_clk_i);
    assign panel_code = sel_code(panel_interface_reg_clk_i[3], panel_interface_reg_clk_i[2],
                                 panel_interface_reg_clk_i[1:0]);

    always_comb begin
        if (panel_mode_i) begin
            code = panel_code;
        end else begin
            code = crt_code;
        end
    end

    // clock chip mode feeds the pixel clock in on pin 1 only
    always_comb begin
        if (clk_chip) begin
            pclk_next = 4'h2;
        end else begin
            pclk_next = osc_pin(code);
        end
    end

    assign index_word = {1'h0, st_ff.index};
    assign version_word = `VERSION_BASE | {4'h0, STEPPING};
    assign data_word = ext_word(st_ff.index, st_ff.strap, version_word);

    // read data only for a read strobe; idle cycles return zero
    always_comb begin
        case ({rd_idx, rd_dat})
            2'h2: begin
                read_word = index_word;
            end
            2'h1: begin
                read_word = data_word;
            end
            default: begin
                read_word = 8'h00;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        if (wr_idx) begin
            nxt_st.index = io_wdata_i[6:0];
        end
        // data port writes have no target: indices 00h and 01h are read-only
        case (st_ff.cap)
            CAP_IDLE: begin
                // strap latched once as reset releases, held until next reset
                nxt_st.strap = pulled;
                nxt_st.cap = CAP_HELD;
            end
            CAP_HELD: begin
                nxt_st.cap = CAP_HELD;
            end
            default: begin
                nxt_st.cap = CAP_IDLE;
            end
        endcase
        nxt_st.rdata = read_word;
        nxt_st.clksel = code;
        nxt_st.pclk_onehot = pclk_next;
    end

    // index and strap keep their contents through reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            // index is a not-changed field; capture is rearmed
            st_ff.cap <= CAP_IDLE;
            st_ff.rdata <= 8'h00;
            st_ff.clksel <= 2'h0;
            st_ff.pclk_onehot <= 4'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pins 2 and 3 turn into select outputs in clock chip mode
    for (genvar p = 0; p < `CLK_PIN_COUNT; p++) begin : g_pin
        if (p < 2) begin : g_in
            assign pin_drive[p] = 1'h0;
            assign pin_level[p] = 1'h0;
        end else begin : g_sel
            assign pin_drive[p] = clk_chip;
            assign pin_level[p] = st_ff.clksel[p - 2];
        end
    end

    assign io_rdata_o = st_ff.rdata;
    assign host_bus_o = bus_of(strap_bus);
    assign pixel_clock_source_sel_o = clk_chip;
    assign memory_clock_freq_sel_o = mclk_slow;
    assign clock_pin_oe_o = pin_drive;
    assign clock_pin_out_o = pin_level;
    assign clock_select_o = st_ff.clksel;
    assign pixel_clock_input_o = st_ff.pclk_onehot;

    // memory clock pin: pin0 in clock chip mode, else by frequency strap
    always_comb begin
        if (clk_chip || mclk_slow) begin
            mclk_pin_o = 2'h0;
        end else begin
            mclk_pin_o = 2'h1;
        end
    end

    // shared pin follows the transceiver strap
    always_comb begin
        if (no_xcvr) begin
            pin82_o = panel_supply_enable_n_i;
        end else begin
            pin82_o = transceiver_read_dir_i;
        end
    end
endmodule

// ==== bench/ext_cfg_monitor.sv ====
// checker of strap outputs and port reads
`timescale 1ns/100ps
module ext_cfg_monitor (
    input wire logic clk_i, nrst_i, io_rd_i, color_base_i, io_hit_o, pin82_o,
    input wire logic transceiver_read_dir_i, panel_supply_enable_n_i,
    input wire logic pixel_clock_source_sel_o, memory_clock_freq_sel_o,
    input wire logic [15:0] io_addr_i,
    input wire logic [7:0] io_rdata_o, memory_address_bus_a_i,
    input wire logic [3:0] clock_pin_oe_o,
    input wire ext_regs_pkg::host_bus_t host_bus_o
);
    logic [1:0] up_ff;
    logic [7:0] s_ff;
    // own copy of the straps, settled two edges after release
    always_ff @(posedge clk_i) begin
        up_ff <= nrst_i ? up_ff + {1'h0, !up_ff[1]} : 2'h0;
        if (nrst_i && up_ff == 2'h0) s_ff <= memory_address_bus_a_i;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_bus; up_ff[1] |-> host_bus_o == s_ff[1:0]; endproperty
    a_bus: assert property (p_bus) else $error("bus type");
    property p_osc; up_ff[1] |-> pixel_clock_source_sel_o == s_ff[2]; endproperty
    a_osc: assert property (p_osc) else $error("clock source");
    property p_mclk; up_ff[1] |-> memory_clock_freq_sel_o == s_ff[3]; endproperty
    a_mclk: assert property (p_mclk) else $error("memory clock");
    property p_oe; up_ff[1] |-> clock_pin_oe_o == {{2{s_ff[2]}}, 2'h0}; endproperty
    a_oe: assert property (p_oe) else $error("pin enables");
    property p_pin;
        up_ff[1] |-> pin82_o == (s_ff[4] ? panel_supply_enable_n_i : transceiver_read_dir_i);
    endproperty
    a_pin: assert property (p_pin) else $error("shared pin");
    property p_idle; !$past(io_rd_i) |-> io_rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data");
    property p_hit; io_hit_o |-> io_addr_i[15:1] == (color_base_i ? 15'h1eb : 15'h1db); endproperty
    a_hit: assert property (p_hit) else $error("decode");
    property p_idx; $past(io_rd_i && io_hit_o && !io_addr_i[0]) |-> !io_rdata_o[7]; endproperty
    a_idx: assert property (p_idx) else $error("index bit 7");
    cover property (io_rd_i && io_hit_o && io_addr_i[0]);
    cover property (up_ff[1] && !pixel_clock_source_sel_o);
    cover property (up_ff[1] && !s_ff[4]);
endmodule
bind ext_index_strap_cfg ext_cfg_monitor mon_u (.*);

// ==== bench/host_io_model.sv ====
// host side issuing byte-wide port cycles
`timescale 1ns/100ps
module host_io_model (
    input wire logic clk_i,
    input wire logic [7:0] io_rdata_o,
    output logic [15:0] io_addr_i,
    output logic io_rd_i, io_wr_i,
    output logic [7:0] io_wdata_i
);
    initial {io_addr_i, io_rd_i, io_wr_i, io_wdata_i} = 26'h0;
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk_i) #1;
        {io_addr_i, io_wr_i, io_rd_i, io_wdata_i} = {a, w, !w, d};
        @(posedge clk_i) #1;
        // released address and data lines show inverted values; both strobes go low
        {io_addr_i, io_wr_i, io_rd_i, io_wdata_i} = {~a, 2'h0, ~d};
        q = io_rdata_o;
    endtask
endmodule

// ==== bench/ext_index_strap_cfg_test.sv ====
// testbench of the extension index and strap block
`timescale 1ns/100ps
`include "ext_regs_defs.svh"
module ext_index_strap_cfg_test;
    import ext_regs_pkg::*;
    localparam logic [3:0] STEP = 4'h3;
    logic clk_i = 1'h0, nrst_i = 1'h0, color_base_i = 1'h1, panel_mode_i = 1'h0, io_hit_o;
    logic transceiver_read_dir_i = 1'h0, panel_supply_enable_n_i = 1'h1, io_rd_i, io_wr_i;
    logic pixel_clock_source_sel_o, memory_clock_freq_sel_o, pin82_o;
    logic [1:0] misc_output_reg_clk_i = 2'h0, feature_control_reg_clk_i = 2'h0;
    logic [1:0] mclk_pin_o, clock_select_o;
    logic [3:0] panel_interface_reg_clk_i = 4'h0, clock_pin_oe_o, clock_pin_out_o;
    logic [3:0] pixel_clock_input_o;
    logic [7:0] io_wdata_i, io_rdata_o, memory_address_bus_a_i = 8'hff, q;
    logic [15:0] io_addr_i;
    host_bus_t host_bus_o;
    int errors = 0, samples_checked = 0;
    always #50 clk_i = ~clk_i;
    ext_index_strap_cfg #(.STEPPING(STEP)) dut_u (.*);
    host_io_model host_u (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_strap(input logic [7:0] p);
        @(posedge clk_i) #1;
        {nrst_i, memory_address_bus_a_i} = {1'h0, p};
        {transceiver_read_dir_i, panel_supply_enable_n_i} = {p[5], !p[5]};
        repeat (4) @(posedge clk_i);
        #1 nrst_i = 1'h1;
        @(posedge clk_i) #1 memory_address_bus_a_i = ~p;
        host_u.acc(16'h03d6, 1'h1, 8'h01, q);
        host_u.acc(16'h03d7, 1'h0, 8'h00, q);
        chk(q, p);
        chk(host_bus_o, p[1:0]);
        chk({clock_pin_oe_o, pixel_clock_source_sel_o}, {p[2], p[2], 2'h0, p[2]});
        chk(memory_clock_freq_sel_o, p[3]);
        chk(pin82_o, p[5] ^ p[4]);
        chk(mclk_pin_o, {1'h0, !(p[2] | p[3])});
    endtask
    task automatic t_sel(input logic pm, input logic [3:0] v, input logic [1:0] c,
        input logic [3:0] oh);
        @(posedge clk_i) #1;
        {panel_mode_i, misc_output_reg_clk_i, feature_control_reg_clk_i} = {pm, v};
        panel_interface_reg_clk_i = v;
        repeat (2) @(posedge clk_i);
        #1 chk(clock_select_o, c);
        chk(clock_pin_out_o, {c, 2'h0});
        chk(pixel_clock_input_o, oh);
    endtask
    task automatic t_ver;
        color_base_i = 1'h0;
        host_u.acc(16'h03b6, 1'h1, 8'hff, q);
        host_u.acc(16'h03b6, 1'h0, 8'h00, q);
        chk(q, 8'h7f);
        host_u.acc(16'h03b7, 1'h0, 8'h00, q);
        chk(q, 8'h00);
        host_u.acc(16'h03b6, 1'h1, 8'h00, q);
        host_u.acc(16'h03b7, 1'h1, 8'h5a, q);
        host_u.acc(16'h03b7, 1'h0, 8'h00, q);
        chk(q, `VERSION_BASE + STEP);
        host_u.acc(16'h03d7, 1'h0, 8'h00, q);
        chk(q, 8'h00);
    endtask
    initial begin
        t_strap(8'hff);
        t_strap(8'h82);
        t_strap(8'h26);
        t_strap(8'h08);
        t_ver;
        t_sel(1'h0, 4'h6, 2'h1, 4'h2);
        t_sel(1'h0, 4'hb, 2'h3, 4'h8);
        t_sel(1'h1, 4'ha, 2'h2, 4'h1);
        t_sel(1'h1, 4'h8, 2'h0, 4'h4);
        conclude;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        conclude;
    end
endmodule
